// [rtl/overlay_blend_pkg.sv]
package overlay_blend_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTL = 8'h04;
    localparam logic [7:0] OFS_ALPHA_CLR = 8'h08;
    localparam logic [7:0] OFS_ALPHA_SET = 8'h0C;
    localparam logic [7:0] OFS_KEY = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_CLIP = 8'h18;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_MSB = 7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_EXT_EN = 0;
    localparam int CTL_FINE_EN = 1;
    localparam int CTL_KEY_EN = 2;
    localparam int CTL_CLIP_EN = 3;
    localparam int CTL_W = 4;
    localparam int STAT_IDENT_BIT = 4;
    localparam int STAT_BWERR_BIT = 5;
    localparam int MASK_Y_LSB = 0;
    localparam int CHROMA_KEY_MASK_LSB = 8;
    localparam int MASK_FLD_W = 3;

    // ------------------------------------------------------------
    // Reset values and fixed limits
    // ------------------------------------------------------------
    localparam logic [31:0] CLIP_RESET = 32'hF010EB10;
    localparam logic [7:0] FIXED_CLIP_LO = 8'h10;
    localparam logic [7:0] FIXED_CLIP_HI = 8'hF0;
    localparam logic [2:0] MASK_MAX = 3'h4;
    localparam logic [7:0] ALPHA_FULL = 8'h80;
    localparam logic [16:0] ROUND_HALF = 17'h00040;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    // ------------------------------------------------------------
    // Pixel carriers: one 4:2:2 pair per transfer
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] y0;
        logic [7:0] y1;
        logic [7:0] u;
        logic [7:0] v;
    } yuv_pair_t;

    typedef struct packed {
        logic in_area;
        yuv_pair_t ovl;
        yuv_pair_t img;
    } pix_in_t;

    typedef struct packed {
        logic in_area;
        yuv_pair_t pix;
    } pix_out_t;

endpackage

// [rtl/overlay_blend_key_clip.sv]
`timescale 1ns/1ps
`default_nettype none

module overlay_blend_key_clip
    import overlay_blend_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    // Pixel stream in
    input wire logic pix_in_valid,
    input wire pix_in_t pix_in,
    input wire logic bw_error,
    // Pixel stream out
    output logic pix_out_valid,
    output pix_out_t pix_out
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] blend(input logic [7:0] a, input logic [7:0] ov,
                                         input logic [7:0] im);
        logic [7:0] w_img;
        logic [16:0] sum;
        w_img = ALPHA_FULL - {1'b0, a[6:0]};
        // Widen each operand first so no product wraps at eight bits
        sum = 17'(a[6:0]) * 17'(ov) + 17'(w_img) * 17'(im) + ROUND_HALF;
        if (a[7]) begin
            return ov;
        end
        return sum[14:7];
    endfunction

    // Bounds of 0 and 255 pass every value through unchanged
    function automatic logic [7:0] clip(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
        if (v <= lo) begin
            return lo;
        end
        if (v >= hi) begin
            return hi;
        end
        return v;
    endfunction

    // Field values above four are held to four masked bits
    function automatic logic [7:0] key_mask(input logic [2:0] n);
        logic [2:0] k;
        k = (n > MASK_MAX) ? MASK_MAX : n;
        return 8'hFF << k;
    endfunction

    function automatic logic key_eq(input logic [7:0] a, input logic [7:0] b,
                                    input logic [7:0] m);
        return ((a ^ b) & m) == 8'h00;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [CTL_W-1:0] ctl_r;
    logic [7:0] alpha_clr_r;
    logic [7:0] alpha_set_r;
    logic [31:0] key_r;
    logic [31:0] mask_r;
    logic [31:0] clip_r;
    logic bw_err_r;

    logic wr_pend_r;
    logic rd_pend_r;
    logic [7:0] wr_addr_r;
    logic [7:0] rd_addr_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic [1:0] hresp_r;

    logic addr_ok;
    assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;

    // Address phase capture; reads take one wait state so any write
    // ahead of them has committed before data is sampled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rd_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            rd_pend_r <= addr_ok && !hwrite;
            if (addr_ok) begin
                wr_addr_r <= haddr[ADDR_MSB:ADDR_LSB];
                rd_addr_r <= haddr[ADDR_MSB:ADDR_LSB];
            end
        end
    end

    // Writes never stall; a read holds ready low for one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b1;
            hresp_r <= HRESP_OKAY;
        end else begin
            hreadyout_r <= !(addr_ok && !hwrite);
            hresp_r <= HRESP_OKAY;
        end
    end

    // Write data phase; status has no write path at all
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_r <= '0;
            alpha_clr_r <= 8'h00;
            alpha_set_r <= 8'h00;
            key_r <= 32'h00000000;
            mask_r <= 32'h00000000;
            clip_r <= CLIP_RESET;
        end else if (wr_pend_r) begin
            unique case (wr_addr_r)
                OFS_CTL: ctl_r <= hwdata[CTL_W-1:0];
                OFS_ALPHA_CLR: alpha_clr_r <= hwdata[7:0];
                OFS_ALPHA_SET: alpha_set_r <= hwdata[7:0];
                OFS_KEY: key_r <= {8'h00, hwdata[23:0]};
                OFS_MASK: mask_r <= {21'h0, hwdata[10:8], 5'h0, hwdata[2:0]};
                OFS_CLIP: clip_r <= hwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bw_err_r <= 1'b0;
        end else begin
            bw_err_r <= bw_error;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
        end else if (rd_pend_r) begin
            hrdata_r <= 32'h00000000;
            unique case (rd_addr_r)
                OFS_STATUS: begin
                    hrdata_r[STAT_IDENT_BIT] <= 1'b1;
                    hrdata_r[STAT_BWERR_BIT] <= bw_err_r;
                end
                OFS_CTL: hrdata_r[CTL_W-1:0] <= ctl_r;
                OFS_ALPHA_CLR: hrdata_r[7:0] <= alpha_clr_r;
                OFS_ALPHA_SET: hrdata_r[7:0] <= alpha_set_r;
                OFS_KEY: hrdata_r <= key_r;
                OFS_MASK: hrdata_r <= mask_r;
                OFS_CLIP: hrdata_r <= clip_r;
                default: ;
            endcase
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;

    // ------------------------------------------------------------
    // Stage 1: keying and blending
    // ------------------------------------------------------------
    logic fine_on;
    logic key_on;
    logic [7:0] alpha_u;
    logic [7:0] alpha_v;
    logic [7:0] eff_u;
    logic [7:0] eff_v;
    logic [7:0] m_y;
    logic [7:0] m_uv;
    logic key_hit0;
    logic key_hit1;

    assign fine_on = ctl_r[CTL_EXT_EN] && ctl_r[CTL_FINE_EN];
    assign key_on = ctl_r[CTL_EXT_EN] && ctl_r[CTL_KEY_EN];
    assign alpha_u = pix_in.ovl.u[0] ? alpha_set_r : alpha_clr_r;
    assign alpha_v = pix_in.ovl.v[0] ? alpha_set_r : alpha_clr_r;
    // Coarse mode keeps only the three top alpha bits: 0, 25, 50, 75 percent, or full overlay when bit 7 is set
    assign eff_u = fine_on ? alpha_u : {alpha_u[7:5], 5'h00};
    assign eff_v = fine_on ? alpha_v : {alpha_v[7:5], 5'h00};
    assign m_y = key_mask(mask_r[MASK_Y_LSB +: MASK_FLD_W]);
    assign m_uv = key_mask(mask_r[CHROMA_KEY_MASK_LSB +: MASK_FLD_W]);
    // Both luma samples share the one chroma pair in the compare
    assign key_hit0 = key_on && key_eq(pix_in.ovl.y0, key_r[7:0], m_y)
        && key_eq(pix_in.ovl.u, key_r[15:8], m_uv)
        && key_eq(pix_in.ovl.v, key_r[23:16], m_uv);
    assign key_hit1 = key_on && key_eq(pix_in.ovl.y1, key_r[7:0], m_y)
        && key_eq(pix_in.ovl.u, key_r[15:8], m_uv)
        && key_eq(pix_in.ovl.v, key_r[23:16], m_uv);

    logic s1_valid_r;
    pix_out_t s1_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_valid_r <= 1'b0;
            s1_r <= '0;
        end else begin
            s1_valid_r <= pix_in_valid;
            if (pix_in_valid) begin
                s1_r.in_area <= pix_in.in_area;
                // Keyed first pixel drops the overlay from y0, u and v; a keyed second pixel only from its luma
                s1_r.pix.y0 <= key_hit0 ? pix_in.img.y0
                    : blend(eff_u, pix_in.ovl.y0, pix_in.img.y0);
                s1_r.pix.y1 <= key_hit1 ? pix_in.img.y1
                    : blend(eff_v, pix_in.ovl.y1, pix_in.img.y1);
                s1_r.pix.u <= key_hit0 ? pix_in.img.u
                    : blend(eff_u, pix_in.ovl.u, pix_in.img.u);
                s1_r.pix.v <= key_hit0 ? pix_in.img.v
                    : blend(eff_u, pix_in.ovl.v, pix_in.img.v);
            end
        end
    end

    // ------------------------------------------------------------
    // Stage 2: clipping, last in the pipeline
    // ------------------------------------------------------------
    logic [7:0] y_lo;
    logic [7:0] y_hi;
    logic [7:0] c_lo;
    logic [7:0] c_hi;
    logic clip_prog;

    assign clip_prog = ctl_r[CTL_CLIP_EN];
    assign y_lo = clip_prog ? clip_r[7:0] : FIXED_CLIP_LO;
    assign y_hi = clip_prog ? clip_r[15:8] : FIXED_CLIP_HI;
    assign c_lo = clip_prog ? clip_r[23:16] : FIXED_CLIP_LO;
    assign c_hi = clip_prog ? clip_r[31:24] : FIXED_CLIP_HI;

    logic pix_out_valid_r;
    pix_out_t pix_out_r;
    logic out_prog_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pix_out_valid_r <= 1'b0;
            pix_out_r <= '0;
            out_prog_r <= 1'b0;
        end else begin
            pix_out_valid_r <= s1_valid_r;
            if (s1_valid_r) begin
                out_prog_r <= clip_prog;
                pix_out_r.in_area <= s1_r.in_area;
                if (s1_r.in_area) begin
                    pix_out_r.pix.y0 <= clip(s1_r.pix.y0, y_lo, y_hi);
                    pix_out_r.pix.y1 <= clip(s1_r.pix.y1, y_lo, y_hi);
                    pix_out_r.pix.u <= clip(s1_r.pix.u, c_lo, c_hi);
                    pix_out_r.pix.v <= clip(s1_r.pix.v, c_lo, c_hi);
                end else begin
                    pix_out_r.pix <= s1_r.pix;
                end
            end
        end
    end

    assign pix_out_valid = pix_out_valid_r;
    assign pix_out = pix_out_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_status_ident: assert property (rd_pend_r && rd_addr_r == OFS_STATUS |=>
        hrdata[STAT_IDENT_BIT] && hreadyout) else $error("status ident bit not 1");
    a_status_ro: assert property (wr_pend_r && wr_addr_r == OFS_STATUS |=>
        $stable(ctl_r) && $stable(clip_r) && $stable(key_r)) else $error("status write had effect");
    a_read_wait: assert property (addr_ok && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_clip_reset: assert property ($rose(hresetn) |-> clip_r == CLIP_RESET)
        else $error("clip bounds reset wrong");
    a_alpha_zero: assert property (pix_in_valid && !key_hit0 && eff_u == 8'h00 |=>
        s1_r.pix.y0 == $past(pix_in.img.y0)) else $error("zero alpha not image");
    a_alpha_full: assert property (pix_in_valid && !key_hit1 && alpha_v[7] |=>
        s1_r.pix.y1 == $past(pix_in.ovl.y1)) else $error("full alpha not overlay");
    a_key_transp: assert property (pix_in_valid && key_hit0 |=>
        s1_r.pix.u == $past(pix_in.img.u)) else $error("keyed overlay visible");
    a_coarse_step: assert property (!fine_on |-> eff_u[4:0] == 5'h00)
        else $error("coarse alpha not 25 percent step");
    a_fixed_clip: assert property (pix_out_valid && pix_out.in_area && !out_prog_r |->
        pix_out.pix.y0 >= FIXED_CLIP_LO && pix_out.pix.y0 <= FIXED_CLIP_HI)
        else $error("fixed clip range violated");
    a_blank_pass: assert property (s1_valid_r && !s1_r.in_area |=>
        pix_out.pix == $past(s1_r.pix)) else $error("blanking was clipped");
    a_pipe_latency: assert property (pix_in_valid |-> ##2 pix_out_valid)
        else $error("pipeline latency not two");
    a_resp_okay: assert property (hresp == HRESP_OKAY)
        else $error("response not okay");
    a_write_nowait: assert property (addr_ok && hwrite |=> hreadyout)
        else $error("write inserted wait state");
    // Keyed second luma must come back as image, never overlay
    a_key_second: assert property (pix_in_valid && key_hit1 |=>
        s1_r.pix.y1 == $past(pix_in.img.y1)) else $error("keyed second luma visible");

    c_keyed: cover property (pix_in_valid && key_hit0);
    c_fine_mix: cover property (pix_in_valid && fine_on && eff_u == 8'h40);
    c_status_read: cover property (rd_pend_r && rd_addr_r == OFS_STATUS);
    c_prog_clip: cover property (pix_out_valid && out_prog_r && pix_out.in_area);
    c_coarse: cover property (pix_in_valid && !fine_on && eff_u != 8'h00);

endmodule // overlay_blend_key_clip

`default_nettype wire

// [dv/overlay_blend_key_clip_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fail_count++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

module overlay_blend_key_clip_tb_top
    import overlay_blend_pkg::*;
;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [1:0] hresp;
    logic pix_in_valid;
    pix_in_t pix_in;
    logic bw_error;
    logic pix_out_valid;
    pix_out_t pix_out;
    logic rdy_q;
    logic [31:0] rd_q;
    logic [1:0] resp_q;
    int fail_count;
    int tests_run;
    int cyc;

    assign hready = hreadyout;

    overlay_blend_key_clip i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pix_in_valid(pix_in_valid),
        .pix_in(pix_in), .bw_error(bw_error), .pix_out_valid(pix_out_valid), .pix_out(pix_out));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Value just before each rising edge, free of update races
    always @(negedge hclk) begin
        rdy_q <= hreadyout;
        rd_q <= hrdata;
        resp_q <= hresp;
    end

    // --------------------------------------------------------
    // Bus and pixel helpers
    // --------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        @(posedge hclk);
        while (rdy_q !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (rdy_q !== 1'b1) @(posedge hclk);
        rd = rd_q;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] ex);
        logic [31:0] got;
        bus(1'b0, a, 32'h00000000, got);
        `CHK("register read", ex, got)
        `CHK("hresp", HRESP_OKAY, resp_q)
    endtask

    function automatic logic [7:0] mix(input logic [7:0] a, input logic [7:0] o,
                                       input logic [7:0] i);
        logic [16:0] s;
        s = a * o + (17'h00080 - a) * i + 17'h00040;
        if (a[7]) return o;
        return s[14:7];
    endfunction

    task automatic px(input logic area, input yuv_pair_t ov, input yuv_pair_t im,
                      input yuv_pair_t ex);
        pix_in_valid <= 1'b1;
        pix_in <= {area, ov, im};
        @(posedge hclk);
        pix_in_valid <= 1'b0;
        @(posedge hclk);
        #1;
        `CHK("pix_out_valid", 1'b1, pix_out_valid)
        `CHK("pix_out", {area, ex}, pix_out)
        @(posedge hclk);
    endtask

    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task automatic t_regs();
        rdchk(OFS_CLIP, 32'hF010EB10);
        rdchk(OFS_STATUS, 32'h00000010);
        wr(OFS_STATUS, 32'h00000030);
        rdchk(OFS_STATUS, 32'h00000010);
        bw_error <= 1'b1;
        @(posedge hclk);
        rdchk(OFS_STATUS, 32'h00000030);
        bw_error <= 1'b0;
        wr(8'h40, 32'h12345678);
        rdchk(8'h40, 32'h00000000);
        wr(OFS_ALPHA_CLR, 32'h00000040);
        rdchk(OFS_ALPHA_CLR, 32'h00000040);
    endtask

    task automatic t_blend();
        yuv_pair_t ov;
        yuv_pair_t im;
        ov = 32'hC833A051;
        im = 32'h20776090;
        wr(OFS_CTL, 32'h00000003);
        wr(OFS_ALPHA_SET, 32'h00000090);
        px(1'b1, ov, im, {mix(8'h40, 8'hC8, 8'h20), 8'h33, mix(8'h40, 8'hA0, 8'h60),
            mix(8'h40, 8'h51, 8'h90)});
        wr(OFS_ALPHA_CLR, 32'h00000000);
        px(1'b1, ov, im, 32'h20336090);
        wr(OFS_ALPHA_CLR, 32'h00000025);
        px(1'b1, ov, im, {mix(8'h25, 8'hC8, 8'h20), 8'h33, mix(8'h25, 8'hA0, 8'h60),
            mix(8'h25, 8'h51, 8'h90)});
        wr(OFS_CTL, 32'h00000009);
        px(1'b1, ov, im, {mix(8'h20, 8'hC8, 8'h20), 8'h33, mix(8'h20, 8'hA0, 8'h60),
            mix(8'h20, 8'h51, 8'h90)});
        wr(OFS_CTL, 32'h0000000A);
        px(1'b1, ov, im, {mix(8'h20, 8'hC8, 8'h20), 8'h33, mix(8'h20, 8'hA0, 8'h60),
            mix(8'h20, 8'h51, 8'h90)});
    endtask

    task automatic t_key();
        wr(OFS_CTL, 32'h00000007);
        wr(OFS_ALPHA_CLR, 32'h00000080);
        wr(OFS_ALPHA_SET, 32'h00000080);
        wr(OFS_KEY, 32'h00706050);
        wr(OFS_MASK, 32'h00000102);
        px(1'b1, 32'h53546071, 32'h20304050, 32'h20544050);
        wr(OFS_CTL, 32'h00000003);
        px(1'b1, 32'h53546071, 32'h20304050, 32'h53546071);
        wr(OFS_CTL, 32'h00000007);
        wr(OFS_MASK, 32'h00000000);
        px(1'b1, 32'h50546071, 32'h20304050, 32'h50546071);
        wr(OFS_MASK, 32'h00000707);
        px(1'b1, 32'h60406F7F, 32'h20304050, 32'h60406F7F);
    endtask

    task automatic t_clip();
        wr(OFS_CTL, 32'h00000009);
        wr(OFS_ALPHA_CLR, 32'h00000000);
        wr(OFS_CLIP, 32'hB040C030);
        px(1'b1, 32'h11111010, 32'h30C52080, 32'h30C04080);
        px(1'b0, 32'h11111010, 32'h30C52080, 32'h30C52080);
        wr(OFS_CTL, 32'h00000001);
        px(1'b1, 32'h11111010, 32'h05FAF50F, 32'h10F0F010);
        wr(OFS_CTL, 32'h00000009);
        wr(OFS_CLIP, 32'hFF00FF00);
        px(1'b1, 32'h11111010, 32'h05FAF50F, 32'h05FAF50F);
    endtask

    task automatic results();
        if (fail_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        fail_count = 0;
        tests_run = 0;
        cyc = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        pix_in_valid = 1'b0;
        pix_in = '0;
        bw_error = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_blend();
        t_key();
        t_clip();
        results();
    end
endmodule // overlay_blend_key_clip_tb_top

`default_nettype wire
